//--- hdl/sfpc_top.sv
// socket force event and supply control register block with apb slave
module sfpc_top
#(
  parameter int PROBE_CYCLES = sfpc_pkg::PROBE_CYCLES
)
(
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire sfpc_pkg::sfpc_apb_req_s apb_req,
  output      logic [31:0]             prdata,
  output      logic                    pready,
  output      logic                    pslverr,
  input  wire logic                    cd1_pin,
  input  wire logic                    cd2_pin,
  input  wire logic                    cst_pin,
  input  wire sfpc_pkg::sfpc_probe_s   card_sense,
  input  wire logic                    socket_idle,
  input  wire logic                    host_clk_stop_pending,
  output      logic [2:0]              vcc_applied,
  output      logic [2:0]              vpp_applied,
  output      logic                    power_ctrl_enable,
  output      logic                    card_clk_stop_permit,
  output      logic                    irq
);

  typedef struct packed {
    logic [31:0]             rdata;
    sfpc_pkg::sfpc_present_s ps;
    logic [3:0]              events;
    logic [3:0]              mask;
    logic [7:0]              ctrl;
    logic [2:0]              vcc_on;
    logic [2:0]              vpp_on;
    logic                    pwr_en;
    logic                    permit;
    logic                    irq;
    logic                    retest_go;
  } sfpc_state_s;

  sfpc_state_s           s;
  sfpc_state_s           next_s;
  logic                  probe_busy;
  logic                  probe_done;
  sfpc_pkg::sfpc_probe_s probe_result;
  logic                  req_valid;
  logic                  access;
  logic                  wr;
  logic                  mapped;
  logic [3:0]            ev_set;
  logic [3:0]            ev_clr;
  logic [31:0]           wd;

  sfpc_interrogator
  #(
    .PROBE_CYCLES (PROBE_CYCLES)
  )
  u_probe
  (
    .sys_clk (sys_clk),
    .srst    (srst),
    .start   (s.retest_go),
    .sense   (card_sense),
    .busy    (probe_busy),
    .done    (probe_done),
    .result  (probe_result)
  );

  sfpc_supply_check u_check
  (
    .vcc_code (apb_req.pwdata[6:4]),
    .vpp_code (apb_req.pwdata[2:0]),
    .card     (s.ps.card),
    .valid    (req_valid)
  );

  always_comb
  begin
    case (apb_req.paddr)
      sfpc_pkg::ADDR_EVENT,
      sfpc_pkg::ADDR_MASK,
      sfpc_pkg::ADDR_PRESENT,
      sfpc_pkg::ADDR_INJECT,
      sfpc_pkg::ADDR_CONTROL,
      sfpc_pkg::ADDR_STATUS: mapped = 1'b1;
      default:               mapped = 1'b0;
    endcase
  end

  assign access = apb_req.psel & apb_req.penable;
  assign wr     = access & apb_req.pwrite & mapped;
  assign wd     = apb_req.pwdata;

  always_comb
  begin
    next_s           = s;
    next_s.retest_go = 1'b0;
    ev_set           = 4'h0;
    ev_clr           = 4'h0;

    // live pins are frozen while the card is probed
    if (!probe_busy)
    begin
      ev_set[2]     = cd2_pin != s.ps.cd2;
      ev_set[1]     = cd1_pin != s.ps.cd1;
      ev_set[0]     = cst_pin != s.ps.cst;
      next_s.ps.cd2 = cd2_pin;
      next_s.ps.cd1 = cd1_pin;
      next_s.ps.cst = cst_pin;
    end
    ev_set[3]         = (s.vcc_on != sfpc_pkg::VCC_OFF) != s.ps.powered;
    next_s.ps.powered = s.vcc_on != sfpc_pkg::VCC_OFF;

    if (probe_done)
    begin
      next_s.ps.card = probe_result;
      next_s.pwr_en  = 1'b1;
    end

    if (wr && apb_req.paddr == sfpc_pkg::ADDR_INJECT)
    begin
      // a forced write lands after a same-cycle probe result
      next_s.ps.card.yy      = wd[sfpc_pkg::BIT_YY];
      next_s.ps.card.xx      = wd[sfpc_pkg::BIT_XX];
      next_s.ps.card.v3      = wd[sfpc_pkg::BIT_V3];
      next_s.ps.card.v5      = wd[sfpc_pkg::BIT_V5];
      if (|wd[sfpc_pkg::BIT_YY:sfpc_pkg::BIT_V5])
        next_s.pwr_en = 1'b0;
      next_s.ps.invalid      = wd[sfpc_pkg::BIT_INVALID];
      next_s.ps.data_loss    = wd[sfpc_pkg::BIT_DATA_LOSS];
      next_s.ps.card.unknown = wd[sfpc_pkg::BIT_UNKNOWN];
      next_s.ps.card.cardbus = wd[sfpc_pkg::BIT_CARDBUS];
      next_s.ps.card.sixteen = wd[sfpc_pkg::BIT_SIXTEEN];
      // bit 6 has no target, so writes to it vanish
      ev_set = ev_set | wd[3:0];
      next_s.retest_go = wd[sfpc_pkg::BIT_RETEST];
    end

    if (wr && apb_req.paddr == sfpc_pkg::ADDR_CONTROL)
    begin
      next_s.ctrl = wd[7:0] & sfpc_pkg::CTRL_WRITE_MASK;
      if (!req_valid)
      begin
        next_s.ps.invalid = 1'b1;
      end
      else
      begin
        next_s.ps.invalid = 1'b0;
        // while power control is off the request is kept but not applied
        if (s.pwr_en)
        begin
          next_s.vcc_on = wd[6:4];
          next_s.vpp_on = wd[2:0];
        end
      end
    end

    if (wr && apb_req.paddr == sfpc_pkg::ADDR_EVENT)
      ev_clr = wd[3:0];
    if (wr && apb_req.paddr == sfpc_pkg::ADDR_MASK)
      next_s.mask = wd[3:0];

    // set wins over a same-cycle clear
    next_s.events = (s.events & ~ev_clr) | ev_set;
    next_s.irq    = |(next_s.events & next_s.mask);

    next_s.permit = socket_idle
                    & (s.ctrl[sfpc_pkg::BIT_POLICY] | host_clk_stop_pending);

    // read data captured in the setup phase so prdata comes from a flop
    if (apb_req.psel && !apb_req.penable)
    begin
      next_s.rdata = 32'h0000_0000;
      case (apb_req.paddr)
        sfpc_pkg::ADDR_EVENT:   next_s.rdata[3:0] = s.events;
        sfpc_pkg::ADDR_MASK:    next_s.rdata[3:0] = s.mask;
        sfpc_pkg::ADDR_PRESENT:
        begin
          next_s.rdata[sfpc_pkg::BIT_SOCK_V3]   = sfpc_pkg::SOCKET_HAS_3V;
          next_s.rdata[sfpc_pkg::BIT_SOCK_V5]   = sfpc_pkg::SOCKET_HAS_5V;
          next_s.rdata[sfpc_pkg::BIT_YY]        = s.ps.card.yy;
          next_s.rdata[sfpc_pkg::BIT_XX]        = s.ps.card.xx;
          next_s.rdata[sfpc_pkg::BIT_V3]        = s.ps.card.v3;
          next_s.rdata[sfpc_pkg::BIT_V5]        = s.ps.card.v5;
          next_s.rdata[sfpc_pkg::BIT_INVALID]   = s.ps.invalid;
          next_s.rdata[sfpc_pkg::BIT_DATA_LOSS] = s.ps.data_loss;
          next_s.rdata[sfpc_pkg::BIT_UNKNOWN]   = s.ps.card.unknown;
          next_s.rdata[sfpc_pkg::BIT_CARDBUS]   = s.ps.card.cardbus;
          next_s.rdata[sfpc_pkg::BIT_SIXTEEN]   = s.ps.card.sixteen;
          next_s.rdata[sfpc_pkg::BIT_POWERED]   = s.ps.powered;
          next_s.rdata[2]                       = s.ps.cd2;
          next_s.rdata[1]                       = s.ps.cd1;
          next_s.rdata[0]                       = s.ps.cst;
        end
        sfpc_pkg::ADDR_INJECT:  next_s.rdata = 32'h0000_0000;
        sfpc_pkg::ADDR_CONTROL: next_s.rdata[7:0] = s.ctrl;
        sfpc_pkg::ADDR_STATUS:
        begin
          next_s.rdata[0]    = s.pwr_en;
          next_s.rdata[1]    = probe_busy;
          next_s.rdata[2]    = s.permit;
          next_s.rdata[6:4]  = s.vcc_on;
          next_s.rdata[10:8] = s.vpp_on;
        end
        default:                next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s        <= '0;
      s.ctrl   <= sfpc_pkg::CTRL_RESET;
      s.mask   <= sfpc_pkg::MASK_RESET;
      s.events <= sfpc_pkg::EVENT_RESET;
      s.pwr_en <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata               = s.rdata;
  assign pready               = access;
  assign pslverr              = access & ~mapped;
  assign vcc_applied          = s.vcc_on;
  assign vpp_applied          = s.vpp_on;
  assign power_ctrl_enable    = s.pwr_en;
  assign card_clk_stop_permit = s.permit;
  assign irq                  = s.irq;

endmodule : sfpc_top

//--- hdl/sfpc_pkg.sv
// constants, types and register map for the socket force event and power control block
package sfpc_pkg;

  localparam logic [7:0] ADDR_EVENT    = 8'h00;
  localparam logic [7:0] ADDR_MASK     = 8'h04;
  localparam logic [7:0] ADDR_PRESENT  = 8'h08;
  localparam logic [7:0] ADDR_INJECT   = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL  = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;

  localparam int BIT_RETEST    = 14;
  localparam int BIT_YY        = 13;
  localparam int BIT_XX        = 12;
  localparam int BIT_V3        = 11;
  localparam int BIT_V5        = 10;
  localparam int BIT_INVALID   = 9;
  localparam int BIT_DATA_LOSS = 8;
  localparam int BIT_UNKNOWN   = 7;
  localparam int BIT_CARDBUS   = 5;
  localparam int BIT_SIXTEEN   = 4;
  localparam int BIT_POWERED   = 3;
  localparam int BIT_POLICY    = 7;
  localparam int BIT_SOCK_V3   = 29;
  localparam int BIT_SOCK_V5   = 28;

  localparam logic [7:0] CTRL_WRITE_MASK = 8'hf7;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [3:0] MASK_RESET      = 4'h0;
  localparam logic [3:0] EVENT_RESET     = 4'h0;

  localparam logic [2:0] VCC_OFF = 3'h0;
  localparam logic [2:0] VCC_5V  = 3'h2;
  localparam logic [2:0] VCC_3V  = 3'h3;
  localparam logic [2:0] VCC_XX  = 3'h4;
  localparam logic [2:0] VCC_YY  = 3'h5;
  localparam logic [2:0] VPP_OFF = 3'h0;
  localparam logic [2:0] VPP_12V = 3'h1;
  localparam logic [2:0] VPP_5V  = 3'h2;
  localparam logic [2:0] VPP_3V  = 3'h3;
  localparam logic [2:0] VPP_XX  = 3'h4;
  localparam logic [2:0] VPP_YY  = 3'h5;

  localparam logic SOCKET_HAS_5V = 1'b1;
  localparam logic SOCKET_HAS_3V = 1'b1;
  localparam logic SOCKET_HAS_XX = 1'b0;
  localparam logic SOCKET_HAS_YY = 1'b0;

  localparam int CLK_PERIOD_NS     = 40;
  localparam int PROBE_TIME_NS     = 400;
  localparam int PROBE_CYCLES      = (PROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sfpc_apb_req_s;

  typedef struct packed {
    logic yy;
    logic xx;
    logic v3;
    logic v5;
    logic unknown;
    logic cardbus;
    logic sixteen;
  } sfpc_probe_s;

  typedef struct packed {
    sfpc_probe_s card;
    logic        invalid;
    logic        data_loss;
    logic        powered;
    logic        cd2;
    logic        cd1;
    logic        cst;
  } sfpc_present_s;

endpackage : sfpc_pkg

//--- hdl/sfpc_supply_check.sv
// supply request checker against socket and card capability
module sfpc_supply_check
(
  input  wire logic [2:0]          vcc_code,
  input  wire logic [2:0]          vpp_code,
  input  wire sfpc_pkg::sfpc_probe_s card,
  output      logic                valid
);

  logic vcc_ok;
  logic vpp_ok;

  always_comb
  begin
    vcc_ok = 1'b0;
    vpp_ok = 1'b0;
    // capability bits already hold the cardbus card's accepted voltages
    case (vcc_code)
      sfpc_pkg::VCC_OFF: vcc_ok = 1'b1;
      sfpc_pkg::VCC_5V:  vcc_ok = card.v5 & sfpc_pkg::SOCKET_HAS_5V;
      sfpc_pkg::VCC_3V:  vcc_ok = card.v3 & sfpc_pkg::SOCKET_HAS_3V;
      sfpc_pkg::VCC_XX:  vcc_ok = card.xx & sfpc_pkg::SOCKET_HAS_XX;
      sfpc_pkg::VCC_YY:  vcc_ok = card.yy & sfpc_pkg::SOCKET_HAS_YY;
      default:           vcc_ok = 1'b0;
    endcase
    case (vpp_code)
      sfpc_pkg::VPP_OFF: vpp_ok = 1'b1;
      sfpc_pkg::VPP_12V: vpp_ok = (vcc_code != sfpc_pkg::VCC_OFF);
      sfpc_pkg::VPP_5V:  vpp_ok = card.v5 & sfpc_pkg::SOCKET_HAS_5V;
      sfpc_pkg::VPP_3V:  vpp_ok = card.v3 & sfpc_pkg::SOCKET_HAS_3V;
      sfpc_pkg::VPP_XX:  vpp_ok = card.xx & sfpc_pkg::SOCKET_HAS_XX;
      sfpc_pkg::VPP_YY:  vpp_ok = card.yy & sfpc_pkg::SOCKET_HAS_YY;
      default:           vpp_ok = 1'b0;
    endcase
    valid = vcc_ok & vpp_ok;
  end

endmodule : sfpc_supply_check

//--- hdl/sfpc_interrogator.sv
// card interrogation timer that samples the card sense inputs
module sfpc_interrogator
#(
  parameter int PROBE_CYCLES = sfpc_pkg::PROBE_CYCLES
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  start,
  input  wire sfpc_pkg::sfpc_probe_s sense,
  output      logic                  busy,
  output      logic                  done,
  output      sfpc_pkg::sfpc_probe_s result
);

  typedef struct packed {
    logic                  busy;
    logic                  done;
    logic [7:0]            cnt;
    sfpc_pkg::sfpc_probe_s result;
  } sfpc_probe_state_s;

  sfpc_probe_state_s s;
  sfpc_probe_state_s next_s;

  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    if (start)
    begin
      // restart wins so a retest during a probe starts over
      next_s.busy = 1'b1;
      next_s.cnt  = 8'(PROBE_CYCLES - 1);
    end
    else if (s.busy)
    begin
      if (s.cnt == 8'h00)
      begin
        next_s.busy   = 1'b0;
        next_s.done   = 1'b1;
        next_s.result = sense;
      end
      else
      begin
        next_s.cnt = s.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s <= '0;
    else
      s <= next_s;
  end

  assign busy   = s.busy;
  assign done   = s.done;
  assign result = s.result;

endmodule : sfpc_interrogator

//--- bench/sfpc_properties.sv
// port-level checks for the socket force event and supply control block
module sfpc_properties
#(
  parameter int PROBE_CYCLES = sfpc_pkg::PROBE_CYCLES
)
(
  input wire logic                    sys_clk,
  input wire logic                    srst,
  input wire sfpc_pkg::sfpc_apb_req_s apb_req,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    socket_idle,
  input wire logic                    host_clk_stop_pending,
  input wire logic [2:0]              vcc_applied,
  input wire logic [2:0]              vpp_applied,
  input wire logic                    power_ctrl_enable,
  input wire logic                    card_clk_stop_permit
);
  // window is the probe plus its register stages exactly, with no slack for a retest restart
  localparam int PW = PROBE_CYCLES + 3;
  wire logic        acc = apb_req.psel & apb_req.penable;
  wire logic        wr  = acc & apb_req.pwrite;
  wire logic        rds = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  wire logic [7:0]  a   = apb_req.paddr;
  wire logic [31:0] d   = apb_req.pwdata;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_zero_wait: assert property (acc |-> pready)
    else $error("access phase without ready");
  a_inject_reads_zero: assert property (
    rds && a == sfpc_pkg::ADDR_INJECT |=> prdata == 32'h0000_0000)
    else $error("inject register read not zero");
  a_ctrl_rsvd_zero: assert property (
    rds && a == sfpc_pkg::ADDR_CONTROL |=> prdata[31:8] == 24'h0 && !prdata[3])
    else $error("control reserved bits not zero");
  a_cap_disables: assert property (
    wr && a == sfpc_pkg::ADDR_INJECT && d[13:10] != 4'h0 |=> !power_ctrl_enable)
    else $error("capability force left power control on");
  a_retest_enables: assert property (
    wr && a == sfpc_pkg::ADDR_INJECT && d[14] |-> ##[1:PW] power_ctrl_enable)
    else $error("retest did not re-enable power control");
  a_reserved_vcc: assert property (
    wr && a == sfpc_pkg::ADDR_CONTROL && d[6:4] inside {3'h1, 3'h6, 3'h7}
    |=> $stable(vcc_applied) && $stable(vpp_applied))
    else $error("reserved supply code changed supply");
  a_supply_cause: assert property (
    !$past(srst) && vcc_applied != $past(vcc_applied) |-> $past(wr)
    && $past(a) == sfpc_pkg::ADDR_CONTROL)
    else $error("supply changed without control write");
  a_vcc_legal: assert property (vcc_applied inside {3'h0, 3'h2, 3'h3})
    else $error("unsupported card supply applied");
  a_vpp_legal: assert property (vpp_applied <= 3'h5)
    else $error("reserved program supply applied");
  a_permit_idle: assert property (
    !$past(srst) && !$past(socket_idle) |-> !card_clk_stop_permit)
    else $error("clock stop permitted while busy");
  a_permit_host: assert property (
    !$past(srst) && $past(socket_idle & host_clk_stop_pending) |-> card_clk_stop_permit)
    else $error("clock stop refused while idle and host stopping");
endmodule : sfpc_properties

bind sfpc_top sfpc_properties #(.PROBE_CYCLES(PROBE_CYCLES)) u_props
(
  .sys_clk              (sys_clk),
  .srst                 (srst),
  .apb_req              (apb_req),
  .prdata               (prdata),
  .pready               (pready),
  .socket_idle          (socket_idle),
  .host_clk_stop_pending(host_clk_stop_pending),
  .vcc_applied          (vcc_applied),
  .vpp_applied          (vpp_applied),
  .power_ctrl_enable    (power_ctrl_enable),
  .card_clk_stop_permit (card_clk_stop_permit)
);

//--- bench/sfpc_card_model.sv
// card in the socket: detect pins and voltage sense
module sfpc_card_model
(
  input  wire logic           present,
  input  wire logic           cardbus,
  output      logic           detect1_n,
  output      logic           detect2_n,
  output      logic           status_chg,
  output sfpc_pkg::sfpc_probe_s sense
);
  timeunit 1ns;
  timeprecision 1ps;
  // detect pins read high with no card
  assign detect1_n  = ~present;
  assign detect2_n  = ~present;
  assign status_chg = 1'b0;
  // cardbus card is 3.3 V only, the 16-bit one 5 V only
  assign sense = !present ? 7'h00 : (cardbus ? 7'h12 : 7'h09);
endmodule : sfpc_card_model

//--- bench/sfpc_top_tb.sv
// self-checking bench for the socket force event and supply control block
module sfpc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 4;
  logic                    sys_clk   = 1'b0;
  logic                    srst      = 1'b1;
  sfpc_pkg::sfpc_apb_req_s req       = '0;
  logic                    idle      = 1'b0;
  logic                    host_stop = 1'b0;
  logic [31:0]             prdata;
  logic                    pready, pslverr, cd1, cd2, cst, pwr_en, permit, irq;
  logic [2:0]              vcc_applied, vpp_applied;
  sfpc_pkg::sfpc_probe_s   sense;
  logic [31:0]             r;
  logic                    e;
  int                      bad_count = 0;
  int                      n_checks  = 0;
  int                      cyc       = 0;

  sfpc_card_model u_card (.present(1'b1), .cardbus(1'b1), .detect1_n(cd1),
    .detect2_n(cd2), .status_chg(cst), .sense(sense));
  sfpc_top #(.PROBE_CYCLES(PC)) dut (.sys_clk(sys_clk), .srst(srst), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cd1_pin(cd1),
    .cd2_pin(cd2), .cst_pin(cst), .card_sense(sense), .socket_idle(idle),
    .host_clk_stop_pending(host_stop), .vcc_applied(vcc_applied),
    .vpp_applied(vpp_applied), .power_ctrl_enable(pwr_en),
    .card_clk_stop_permit(permit), .irq(irq));

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
      report_and_stop(1);
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    // wait states are legal, so poll ready at each edge
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic t_inject();
    apb(0, sfpc_pkg::ADDR_CONTROL, 0, r, e);
    chk(r, 32'h0000_0000);
    chk(pwr_en, 1'b1);
    apb(1, sfpc_pkg::ADDR_INJECT, 32'hffff_bfff, r, e);
    // register updates on the write edge, so look after it settles
    #1 chk(pwr_en, 1'b0);
    apb(0, sfpc_pkg::ADDR_INJECT, 0, r, e);
    chk(r, 32'h0000_0000);
    apb(0, sfpc_pkg::ADDR_PRESENT, 0, r, e);
    chk(r, 32'h3000_3fb0);
    apb(0, sfpc_pkg::ADDR_EVENT, 0, r, e);
    chk(r, 32'h0000_000f);
    apb(1, sfpc_pkg::ADDR_INJECT, 0, r, e);
    apb(0, sfpc_pkg::ADDR_PRESENT, 0, r, e);
    chk(r, 32'h3000_0000);
    apb(1, sfpc_pkg::ADDR_EVENT, 32'h0000_000f, r, e);
    apb(0, sfpc_pkg::ADDR_EVENT, 0, r, e);
    chk(r, 32'h0000_0000);
  endtask : t_inject

  task automatic t_irq();
    apb(1, sfpc_pkg::ADDR_INJECT, 32'h0000_0001, r, e);
    #1 chk(irq, 1'b0);
    apb(1, sfpc_pkg::ADDR_MASK, 32'h0000_0001, r, e);
    #1 chk(irq, 1'b1);
    apb(1, sfpc_pkg::ADDR_EVENT, 32'h0000_0001, r, e);
    #1 chk(irq, 1'b0);
    apb(1, sfpc_pkg::ADDR_MASK, 0, r, e);
  endtask : t_irq

  task automatic t_retest();
    apb(1, sfpc_pkg::ADDR_INJECT, 32'h0000_4000, r, e);
    repeat (PC + 4) @(posedge sys_clk);
    apb(0, sfpc_pkg::ADDR_PRESENT, 0, r, e);
    chk(r, 32'h3000_0820);
    chk(pwr_en, 1'b1);
    apb(0, sfpc_pkg::ADDR_STATUS, 0, r, e);
    chk(r, 32'h0000_0001);
  endtask : t_retest

  task automatic t_supply();
    logic [19:0] t;
    logic [19:0] tbl [12] = '{20'h3_0300, 20'h2_0301, 20'h1_0301, 20'h4_0301,
      20'h5_0301, 20'h6_0301, 20'h7_0301, 20'h3_1310, 20'h3_2311, 20'h3_6311,
      20'h3_3330, 20'h0_0000};
    for (int i = 0; i < 12; i++)
    begin
      t = tbl[i];
      apb(1, sfpc_pkg::ADDR_CONTROL, {24'h0, 1'b0, t[18:16], 1'b1, t[14:12]}, r, e);
      apb(0, sfpc_pkg::ADDR_CONTROL, 0, r, e);
      chk(r, {24'h0, 1'b0, t[18:16], 1'b0, t[14:12]});
      apb(0, sfpc_pkg::ADDR_PRESENT, 0, r, e);
      chk(r[9], t[0]);
      chk({vcc_applied, vpp_applied}, {t[10:8], t[6:4]});
    end
  endtask : t_supply

  task automatic t_disabled();
    // forced capability means power control is off: request is only stored
    apb(1, sfpc_pkg::ADDR_INJECT, 32'h0000_0800, r, e);
    apb(1, sfpc_pkg::ADDR_CONTROL, 32'h0000_0030, r, e);
    apb(0, sfpc_pkg::ADDR_PRESENT, 0, r, e);
    chk(r[9], 1'b0);
    chk(vcc_applied, 3'h0);
    apb(1, sfpc_pkg::ADDR_CONTROL, 0, r, e);
    apb(0, 8'h20, 0, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
  endtask : t_disabled

  task automatic t_reset();
    // mid-run reset must restore power control, clear control and events
    apb(1, sfpc_pkg::ADDR_CONTROL, 32'h0000_0080, r, e);
    apb(1, sfpc_pkg::ADDR_MASK, 32'h0000_000f, r, e);
    #1 chk(irq, 1'b1);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1 chk(pwr_en, 1'b1);
    chk(irq, 1'b0);
    chk(vcc_applied, 3'h0);
    apb(0, sfpc_pkg::ADDR_CONTROL, 0, r, e);
    chk(r, 32'h0000_0000);
  endtask : t_reset

  task automatic t_policy();
    for (int i = 0; i < 8; i++)
    begin
      apb(1, sfpc_pkg::ADDR_CONTROL, {24'h0, i[2], 7'h0}, r, e);
      idle      <= i[1];
      host_stop <= i[0];
      repeat (2) @(posedge sys_clk);
      #1 chk(permit, i[1] & (i[2] | i[0]));
    end
  endtask : t_policy

  task automatic report_and_stop(input int t);
    bad_count += t;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    t_inject();
    t_irq();
    t_retest();
    t_supply();
    t_disabled();
    t_reset();
    t_policy();
    report_and_stop(0);
  end
endmodule : sfpc_top_tb
